// [src/ctm_timer_map.svh]
// Register offsets, field positions, reset values and divider counts of the compact timer.
`ifndef CTM_TIMER_MAP_SVH
`define CTM_TIMER_MAP_SVH

// ********************************************************
// Register offsets (word index on the plain register port)
// ********************************************************
`define CTM_REG_CTRL0       4'h0
`define CTM_REG_CTRL1       4'h1
`define CTM_REG_FULL_COMPARE_VALUE        4'h2
`define CTM_REG_COARSE_PERIOD_VALUE        4'h3
`define CTM_REG_COUNT       4'h4
`define CTM_REG_FLAGS       4'h5

// ********************************************************
// Field positions
// ********************************************************
`define CTM_CTRL0_ENABLE    0
`define CTM_CTRL0_CLKSEL_LO 1
`define CTM_CTRL0_CLKSEL_HI 2
`define CTM_FLAGS_A         0
`define CTM_FLAGS_P         1

// ********************************************************
// Reset values
// ********************************************************
`define CTM_RST_CTRL0       3'h0
`define CTM_RST_CTRL1       8'h00
`define CTM_RST_BYTE        16'h0000

// ********************************************************
// Prescaler terminal counts (divisor minus one)
// ********************************************************
`define CTM_DIV_SEL_1       6'h00
`define CTM_DIV_SEL_4       6'h03
`define CTM_DIV_SEL_16      6'h0F
`define CTM_DIV_SEL_64      6'h3F

`endif

// [src/ctm_pkg.sv]
// Types shared by the compact timer modules.
package ctm_pkg;

   typedef enum logic [1:0] {
      CTM_MODE_CMP   = 2'b00,
      CTM_MODE_UNDEF = 2'b01,
      CTM_MODE_PWM   = 2'b10,
      CTM_MODE_TMR   = 2'b11
   } ctm_mode_t;

   // Bit layout of the timer_control_one register, msb first.
   typedef struct packed {
      ctm_mode_t  mode;
      logic [1:0] pin_action;
      logic       output_initial_level;
      logic       output_invert;
      logic       duty_period_swap;
      logic       clear_select;
   } ctm_ctrl_t;

endpackage : ctm_pkg

// [src/ctm_tick_divider.sv]
// Timer clock prescaler that issues one-cycle tick enables.
`timescale 1ns/1ps
`include "ctm_timer_map.svh"

module ctm_tick_divider (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [1:0] sel,
   output logic            tick
);

   logic [5:0] div_cnt;
   logic [5:0] limit;
   logic [5:0] next_div_cnt;

   assign limit = (sel == 2'b00) ? `CTM_DIV_SEL_1 :
                  (sel == 2'b01) ? `CTM_DIV_SEL_4 :
                  (sel == 2'b10) ? `CTM_DIV_SEL_16 : `CTM_DIV_SEL_64;

   assign tick         = run && !restart && (div_cnt >= limit);
   assign next_div_cnt = (restart || tick) ? 6'h00 : (run ? div_cnt + 6'h01 : div_cnt);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_cnt <= 6'h00;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

endmodule : ctm_tick_divider

// [src/ctm_pin_out.sv]
// Output pin logic of the compact timer: compare action, PWM waveform and polarity.
`timescale 1ns/1ps

module ctm_pin_out #(
   parameter int CNT_W = 10
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire ctm_pkg::ctm_ctrl_t ctrl,
   input  wire logic              enable_rise,
   input  wire logic              a_hit,
   input  wire logic [CNT_W-1:0]  count,
   input  wire logic [CNT_W:0]    duty,
   output logic                   timer_output_pin,
   output logic                   timer_output_pin_oe_n
);

   logic cmp_level;
   logic next_cmp_level;
   logic wave_active;
   logic pwm_active;
   logic pwm_level;
   logic is_cmp;
   logic is_pwm;
   logic next_pin;

   assign is_cmp = (ctrl.mode == ctm_pkg::CTM_MODE_CMP);
   assign is_pwm = (ctrl.mode == ctm_pkg::CTM_MODE_PWM);

   // Compare state: initial level on enable rise, else the action on an A match.
   assign next_cmp_level = enable_rise ? ctrl.output_initial_level :
                           !(a_hit && is_cmp) ? cmp_level :
                           (ctrl.pin_action == 2'b01) ? 1'b0 :
                           (ctrl.pin_action == 2'b10) ? 1'b1 :
                           (ctrl.pin_action == 2'b11) ? ~cmp_level : cmp_level;

   // PWM: with pin_action 2'b10 active while the count is below the duty; duty at or above period keeps it active.
   assign wave_active = ({1'b0, count} < duty);
   assign pwm_active  = (ctrl.pin_action == 2'b01) ||
                        ((ctrl.pin_action == 2'b10) && wave_active);
   assign pwm_level   = pwm_active ? ctrl.output_initial_level : ~ctrl.output_initial_level;

   assign next_pin = (is_pwm ? pwm_level : next_cmp_level) ^ ctrl.output_invert;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmp_level             <= 1'b0;
         timer_output_pin      <= 1'b0;
         timer_output_pin_oe_n <= 1'b1;
      end else begin
         cmp_level             <= next_cmp_level;
         timer_output_pin      <= next_pin;
         timer_output_pin_oe_n <= !(is_cmp || is_pwm);
      end
   end

endmodule : ctm_pin_out

// [src/ctm_compact_timer.sv]
// Compact timer top: register port, 10-bit up-counter, comparators A and P, flags.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "ctm_timer_map.svh"

module ctm_compact_timer #(
   parameter int CNT_W  = 10,
   parameter int COARSE_PERIOD_VALUE_W = 3
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]      rdata,
   output logic             timer_output_pin,
   output logic             timer_output_pin_oe_n,
   output logic             match_a_flag,
   output logic             match_p_flag
);

   // ********************************************************
   // Elaboration checks
   // ********************************************************
   if (CNT_W < 2 || CNT_W > 15 || COARSE_PERIOD_VALUE_W < 1 || COARSE_PERIOD_VALUE_W >= CNT_W) begin : g_bad_width
      $error("ctm_compact_timer: unsupported counter or period width");
   end

   localparam int LOW_W = CNT_W - COARSE_PERIOD_VALUE_W;

   // ********************************************************
   // Registers
   // ********************************************************
   logic                     module_enable;
   logic [1:0]               clk_sel;
   ctm_pkg::ctm_ctrl_t       timer_control_one;
   logic [CNT_W-1:0]         full_compare_value;
   logic [COARSE_PERIOD_VALUE_W-1:0]        coarse_period_value;
   logic [CNT_W-1:0]         count;
   logic                     enable_d;

   // ********************************************************
   // Register decode
   // ********************************************************
   wire wr_ctrl0 = wr && (addr == `CTM_REG_CTRL0);
   wire wr_ctrl1 = wr && (addr == `CTM_REG_CTRL1);
   wire wr_full_compare_value  = wr && (addr == `CTM_REG_FULL_COMPARE_VALUE);
   wire wr_coarse_period_value  = wr && (addr == `CTM_REG_COARSE_PERIOD_VALUE);
   wire wr_flags = wr && (addr == `CTM_REG_FLAGS);

   wire [15:0] rd_ctrl0 = {13'h0000, clk_sel, module_enable};
   wire [15:0] rd_ctrl1 = {8'h00, timer_control_one};
   wire [15:0] rd_full_compare_value  = 16'(full_compare_value);
   wire [15:0] rd_coarse_period_value  = 16'(coarse_period_value);
   wire [15:0] rd_count = 16'(count);
   wire [15:0] rd_flags = {14'h0000, match_p_flag, match_a_flag};

   // Unmapped offsets read as zero.
   wire [15:0] rd_mux = (addr == `CTM_REG_CTRL0) ? rd_ctrl0 :
                        (addr == `CTM_REG_CTRL1) ? rd_ctrl1 :
                        (addr == `CTM_REG_FULL_COMPARE_VALUE)  ? rd_full_compare_value  :
                        (addr == `CTM_REG_COARSE_PERIOD_VALUE)  ? rd_coarse_period_value  :
                        (addr == `CTM_REG_COUNT) ? rd_count :
                        (addr == `CTM_REG_FLAGS) ? rd_flags : `CTM_RST_BYTE;

   // ********************************************************
   // Timer clock
   // ********************************************************
   logic tick;
   wire  enable_rise = module_enable && !enable_d;

   ctm_tick_divider u_div (
      .clk     (clk),
      .resetn  (resetn),
      .run     (module_enable),
      .restart (enable_rise),
      .sel     (clk_sel),
      .tick    (tick)
   );

   // ********************************************************
   // Comparators
   // ********************************************************
   wire                  is_pwm    = (timer_control_one.mode == ctm_pkg::CTM_MODE_PWM);
   wire                  swap      = timer_control_one.duty_period_swap;
   wire                  clr_sel   = timer_control_one.clear_select;
   wire [CNT_W-1:0]      count_inc = CNT_W'(count + 1'b1);
   wire [CNT_W-1:0]      p_value   = {coarse_period_value, {LOW_W{1'b0}}};
   wire                  full_compare_value_zero = (full_compare_value == '0);
   wire                  coarse_period_value_zero = (coarse_period_value == '0);

   // A match excludes a zero compare value, so the wrap at all ones raises no A flag.
   wire a_hit    = tick && !full_compare_value_zero && (count_inc == full_compare_value);
   // P matches the period in the upper bits with the lower bits zero; a zero period matches on the overflow itself.
   wire p_hit    = tick && (count_inc == p_value);
   wire overflow = tick && (&count);

   // PWM ignores the clear select; P clears the counter, or A (and overflow) when duty_period_swap is set.
   wire clear_on = is_pwm ? (swap ? (a_hit || overflow) : p_hit) :
                            (clr_sel ? (a_hit || overflow) : p_hit);

   wire set_a = a_hit;
   wire set_p = p_hit && (is_pwm || !clr_sel);

   wire [CNT_W-1:0] next_count = enable_rise ? '0 :
                                 !tick ? count :
                                 clear_on ? '0 : count_inc;

   // ********************************************************
   // PWM duty selection
   // ********************************************************
   wire [CNT_W:0] coarse_full = coarse_period_value_zero ? (CNT_W+1)'(1) << CNT_W :
                                {1'b0, coarse_period_value, {LOW_W{1'b0}}};
   wire [CNT_W:0] pwm_duty    = swap ? coarse_full : {1'b0, full_compare_value};

   // Flags: a set arriving with a write-one clear wins.
   wire next_a_flag = (match_a_flag && !(wr_flags && wdata[`CTM_FLAGS_A])) || set_a;
   wire next_p_flag = (match_p_flag && !(wr_flags && wdata[`CTM_FLAGS_P])) || set_p;

   // ********************************************************
   // Register state
   // ********************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {clk_sel, module_enable} <= `CTM_RST_CTRL0;
         timer_control_one        <= `CTM_RST_CTRL1;
      end else begin
         if (wr_ctrl0) begin
            clk_sel       <= wdata[`CTM_CTRL0_CLKSEL_HI:`CTM_CTRL0_CLKSEL_LO];
            module_enable <= wdata[`CTM_CTRL0_ENABLE];
         end
         if (wr_ctrl1) begin
            timer_control_one <= ctm_pkg::ctm_ctrl_t'(wdata[7:0]);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         full_compare_value  <= '0;
         coarse_period_value <= '0;
      end else begin
         if (wr_full_compare_value) begin
            full_compare_value <= wdata[CNT_W-1:0];
         end
         if (wr_coarse_period_value) begin
            coarse_period_value <= wdata[COARSE_PERIOD_VALUE_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count        <= '0;
         enable_d     <= 1'b0;
         match_a_flag <= 1'b0;
         match_p_flag <= 1'b0;
         rdata        <= `CTM_RST_BYTE;
      end else begin
         count        <= next_count;
         enable_d     <= module_enable;
         match_a_flag <= next_a_flag;
         match_p_flag <= next_p_flag;
         rdata        <= rd ? rd_mux : `CTM_RST_BYTE;
      end
   end

   // ********************************************************
   // Output pin
   // ********************************************************
   ctm_pin_out #(
      .CNT_W (CNT_W)
   ) u_pin (
      .clk                   (clk),
      .resetn                (resetn),
      .ctrl                  (timer_control_one),
      .enable_rise           (enable_rise),
      .a_hit                 (a_hit),
      .count                 (count),
      .duty                  (pwm_duty),
      .timer_output_pin      (timer_output_pin),
      .timer_output_pin_oe_n (timer_output_pin_oe_n)
   );

endmodule : ctm_compact_timer

// [test/ctm_compact_timer_props.sv]
// Port-level assertions for the compact timer, bound to its top module.
`timescale 1ns/1ps
`include "ctm_timer_map.svh"

module ctm_compact_timer_props #(
   parameter int CNT_W  = 10,
   parameter int COARSE_PERIOD_VALUE_W = 3
) (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   input wire logic        timer_output_pin,
   input wire logic        timer_output_pin_oe_n,
   input wire logic        match_a_flag,
   input wire logic        match_p_flag
);
   ctm_pkg::ctm_ctrl_t ctl_q;
   logic               en_q;
   logic [CNT_W-1:0]   full_compare_value_q;
   wire                clr_a = wr && addr == `CTM_REG_FLAGS && wdata[`CTM_FLAGS_A];
   wire                clr_p = wr && addr == `CTM_REG_FLAGS && wdata[`CTM_FLAGS_P];
   wire                pwm   = ctl_q.mode == ctm_pkg::CTM_MODE_PWM;
   wire                lvl   = ctl_q.pin_action[0] ? ctl_q.output_initial_level : !ctl_q.output_initial_level;

   // Shadow copies of the control registers, taken from the write strobes.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctl_q  <= '0;
         en_q   <= 1'b0;
         full_compare_value_q <= '0;
      end else if (wr) begin
         if (addr == `CTM_REG_CTRL0) en_q <= wdata[`CTM_CTRL0_ENABLE];
         if (addr == `CTM_REG_CTRL1) ctl_q <= wdata[7:0];
         if (addr == `CTM_REG_FULL_COMPARE_VALUE) full_compare_value_q <= wdata[CNT_W-1:0];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_tmr_pin_free: assert property ((ctl_q.mode == ctm_pkg::CTM_MODE_TMR) [*2] |-> timer_output_pin_oe_n)
      else $error("pin driven in timer mode");
   a_pin_driven: assert property ((resetn && ctl_q.mode inside {ctm_pkg::CTM_MODE_CMP, ctm_pkg::CTM_MODE_PWM}) [*2]
      |-> !timer_output_pin_oe_n)
      else $error("pin not driven");
   a_flag_a_sticky: assert property (match_a_flag && !clr_a |=> match_a_flag)
      else $error("A flag lost");
   a_flag_p_sticky: assert property (match_p_flag && !clr_p |=> match_p_flag)
      else $error("P flag lost");
   a_p_flag_barred: assert property ($rose(match_p_flag) |-> !($past(ctl_q.clear_select) && !$past(pwm)))
      else $error("P flag with A clear");
   a_a_zero_quiet: assert property ($rose(match_a_flag) |-> $past(full_compare_value_q) != '0)
      else $error("A flag with zero compare");
   a_cmp_pin_hold: assert property ((en_q && ctl_q.mode == ctm_pkg::CTM_MODE_CMP && ctl_q.pin_action == 2'b00) [*5]
      |-> $stable(timer_output_pin))
      else $error("pin moved with no action");
   a_pwm_forced: assert property ((en_q && pwm && !ctl_q.pin_action[1]) [*3]
      |-> timer_output_pin == (lvl ^ ctl_q.output_invert))
      else $error("forced level wrong");
   a_idle_no_flag: assert property ((!en_q) [*4] |-> !$rose(match_a_flag) && !$rose(match_p_flag))
      else $error("flag while disabled");
endmodule : ctm_compact_timer_props

bind ctm_compact_timer ctm_compact_timer_props #(.CNT_W(CNT_W), .COARSE_PERIOD_VALUE_W(COARSE_PERIOD_VALUE_W)) props_u (
   .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .timer_output_pin(timer_output_pin), .timer_output_pin_oe_n(timer_output_pin_oe_n),
   .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

// [test/ctm_compact_timer_bench.sv]
// Self-checking bench of the compact timer: registers, compare, timer and PWM modes.
`timescale 1ns/1ps
`include "ctm_timer_map.svh"

module ctm_compact_timer_bench;
   logic        clk;
   logic        resetn;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        pin;
   logic        oe_n;
   logic        fa;
   logic        fp;
   int          errors;
   int          comparisons;

   ctm_compact_timer #(.CNT_W(10), .COARSE_PERIOD_VALUE_W(3)) dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .timer_output_pin(pin), .timer_output_pin_oe_n(oe_n),
      .match_a_flag(fa), .match_p_flag(fp));

   always #2.5 clk = ~clk;

   task automatic tally_and_finish();
      if (errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [15:0] flags();
      return {14'h0, fp, fa};
   endfunction : flags

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd

   // Restarts the timer with new settings; the enable rise reloads the pin.
   task automatic start(input logic [15:0] c1, input logic [15:0] ctl0);
      reg_wr(`CTM_REG_CTRL0, 16'h0000);
      reg_wr(`CTM_REG_CTRL1, c1);
      reg_wr(`CTM_REG_FLAGS, 16'h0003);
      reg_wr(`CTM_REG_CTRL0, ctl0);
   endtask : start

   task automatic wait_flag(input logic sel_p, input int lim, output int n);
      n = 0;
      while ((sel_p ? fp : fa) !== 1'b1) begin
         cyc(1);
         n++;
         if (n > lim) begin
            errors++;
            tally_and_finish();
         end
      end
   endtask : wait_flag

   task automatic t_regs();
      logic [15:0] v;
      reg_wr(4'hF, 16'hFFFF);
      for (int i = 0; i < 16; i++) begin
         reg_rd(i[3:0], v);
         chk(v, 16'h0000);
      end
      reg_wr(`CTM_REG_CTRL1, 16'h00BE);
      reg_rd(`CTM_REG_CTRL1, v);
      chk(v, 16'h00BE);
   endtask : t_regs

   task automatic t_cmp_p();
      int          n;
      logic [15:0] v;
      logic [15:0] w;
      reg_wr(`CTM_REG_FULL_COMPARE_VALUE, 16'h0040);
      reg_wr(`CTM_REG_COARSE_PERIOD_VALUE, 16'h0001);
      start(16'h0030, 16'h0001);
      wait_flag(1'b1, 300, n);
      chk(16'(n >= 120 && n <= 136), 16'h0001);
      chk(flags(), 16'h0003);
      chk(16'(pin), 16'h0001);
      reg_wr(`CTM_REG_CTRL0, 16'h0000);
      cyc(2);
      reg_rd(`CTM_REG_COUNT, v);
      cyc(20);
      reg_rd(`CTM_REG_COUNT, w);
      chk(w, v);
      reg_wr(`CTM_REG_FLAGS, 16'h0003);
      cyc(1);
      chk(flags(), 16'h0000);
   endtask : t_cmp_p

   task automatic t_cmp_a();
      int          n;
      logic        exp;
      logic [15:0] v;
      reg_wr(`CTM_REG_FULL_COMPARE_VALUE, 16'h00A0);
      for (int i = 0; i < 8; i++) begin
         start({8'h00, 2'b00, i[1:0], i[2], 3'b001}, 16'h0001);
         cyc(4);
         chk(16'(pin), 16'(i[2]));
         wait_flag(1'b0, 400, n);
         cyc(3);
         exp = (i[1:0] == 2'b00) ? i[2] : (i[1:0] == 2'b11) ? !i[2] : i[1];
         chk(16'(pin), 16'(exp));
         chk(16'(fp), 16'h0000);
      end
      reg_wr(`CTM_REG_CTRL0, 16'h0000);
      reg_wr(`CTM_REG_FULL_COMPARE_VALUE, 16'h0000);
      start(16'h0001, 16'h0001);
      cyc(1100);
      reg_rd(`CTM_REG_COUNT, v);
      chk(16'(v < 16'h00C8), 16'h0001);
      chk(flags(), 16'h0000);
   endtask : t_cmp_a

   task automatic t_tmr();
      int n;
      reg_wr(`CTM_REG_FULL_COMPARE_VALUE, 16'h0040);
      start(16'h00C0, 16'h0003);
      wait_flag(1'b1, 1000, n);
      chk(16'(n >= 500 && n <= 540), 16'h0001);
      chk(flags(), 16'h0003);
      chk(16'(oe_n), 16'h0001);
   endtask : t_tmr

   // Any window one period long holds exactly the active count of the waveform.
   task automatic pwm_run(input logic [7:0] c, input logic [15:0] a, input int per, input int hi, input logic [1:0] f);
      int n;
      reg_wr(`CTM_REG_FULL_COMPARE_VALUE, a);
      start({8'h00, c}, 16'h0001);
      cyc(per + 8);
      n = 0;
      repeat (per) begin
         cyc(1);
         n += int'(pin === 1'b1);
      end
      chk(16'(n), 16'(hi));
      chk(flags(), {14'h0, f});
   endtask : pwm_run

   initial begin
      clk         = 1'b0;
      resetn      = 1'b0;
      addr        = 4'h0;
      wdata       = 16'h0000;
      wr          = 1'b0;
      rd          = 1'b0;
      errors      = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_cmp_p();
      t_cmp_a();
      t_tmr();
      pwm_run(8'hA8, 16'h0020, 128, 32, 2'b11);
      pwm_run(8'hA0, 16'h0020, 128, 96, 2'b11);
      pwm_run(8'hAD, 16'h0020, 128, 96, 2'b11);
      pwm_run(8'hA8, 16'h0090, 128, 128, 2'b10);
      pwm_run(8'hAA, 16'h0100, 256, 128, 2'b11);
      pwm_run(8'h98, 16'h0020, 128, 128, 2'b11);
      pwm_run(8'h88, 16'h0020, 128, 0, 2'b11);
      tally_and_finish();
   end

   initial begin
      #400000;
      errors++;
      tally_and_finish();
   end
endmodule : ctm_compact_timer_bench
